// ===== verilog/alarm_aggregator.sv
// Alarm flag collection, masking, summary bit and AHB-Lite register slave
//
// The AHB-Lite register port was left to the implementer.
`default_nettype none

// Overview of operation
// RL1: The summary alarm bit is 1 whenever any flag is set whose mask bit is clear.
// RL2: The summary alarm bit reads at bit 0 of the read-only summary register, other bits reading zero.
// RL3: Each flag has its own mask bit so software can keep it out of the summary.
// RL4: When the pin select bit chooses it, the summary alarm drives the status output pin.
// RL5: The PLL unlock flag at bit 4 is set while the PLL is not locked.
// RL6: The link flag at bit 3 is set while the link is enabled but not in its data transfer state.
// RL7: The clock realign flag at bit 2 is set when a SYSREF event realigns the internal clocks.
// RL8: The oscillator phase flag at bit 1 is set while the link enable bit is 0.
// RL9: The oscillator phase flag is set whenever the oscillators are synchronized.
// RL10: The oscillator phase flag is set whenever a channel A phase accumulator differs from channel B.
// RL11: The divider mismatch flag at bit 0 is set whenever the A and B clock dividers differ.
// RL12: Writing 1 to a flag bit clears it and writing 0 leaves it unchanged.
// RL13: The flags register resets to 0x1F with the upper three bits reading zero.
// RL14: Each mask bit sits at its flag's position and a set mask bit keeps that flag out of the summary.
// RL15: The mask register resets to 0x1F so all alarms start masked.
// RL16: A cause present in the same cycle as a clear keeps the flag set.
// RL17: The summary is computed combinationally from flags and masks and needs no clear.
module alarm_aggregator #(
    parameter int unsigned ACC_COUNT = 2,
    parameter int unsigned ACC_WIDTH = 32,
    parameter int unsigned DIV_WIDTH = 8
) (
    input  wire logic                           clk_sys,
    input  wire logic                           sys_rst,
    input  wire logic                           hsel,
    input  wire logic [31:0]                    haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic                           hready,
    input  wire logic [31:0]                    hwdata,
    output logic      [31:0]                    hrdata,
    output logic                                hreadyout,
    output logic                                hresp,
    input  wire logic                           pll_locked,
    input  wire logic                           link_enable_bit,
    input  wire logic                           data_transfer_state,
    input  wire logic                           sysref_realign,
    input  wire logic                           oscillator_sync,
    input  wire logic [ACC_COUNT*ACC_WIDTH-1:0] phase_acc_a,
    input  wire logic [ACC_COUNT*ACC_WIDTH-1:0] phase_acc_b,
    input  wire logic [DIV_WIDTH-1:0]           divider_a,
    input  wire logic [DIV_WIDTH-1:0]           divider_b,
    input  wire logic                           calibration_status,
    output logic                                status_output_pin,
    output logic                                irq
);

    function automatic logic [31:0] pad_word(input logic [4:0] v);
        pad_word = {27'h0000000, v};
    endfunction

    function automatic logic [4:0] apply_w1c(input logic [4:0] cur, input logic [4:0] clr, input logic [4:0] set);
        apply_w1c = (cur & ~clr) | set;
    endfunction

    function automatic logic wr_hit(input logic active, input logic [9:0] cur, input logic [9:0] target);
        wr_hit = active & (cur == target);
    endfunction

    alarm_aggregator_pkg::bus_state_type bus_state_reg;
    alarm_aggregator_pkg::bus_state_type bus_state_next;
    logic [9:0]  idx_reg;
    logic [9:0]  idx_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;

    logic [4:0]  alarm_flags_reg;
    logic [4:0]  alarm_flags_next;
    logic [4:0]  alarm_enable_mask_reg;
    logic [4:0]  alarm_enable_mask_next;
    logic [4:0]  irq_enable_reg;
    logic [4:0]  irq_enable_next;
    logic        pin_select_reg;
    logic        pin_select_next;
    logic        status_pin_reg;
    logic        status_pin_next;
    logic        irq_reg;
    logic        irq_next;

    logic        addr_take;
    logic        wr_active;
    logic [4:0]  set_vec;
    logic [4:0]  clr_vec;
    logic        alarm_summary;
    logic [4:0]  unmasked_flags;
    logic [31:0] read_value;

    logic        pll_unlock_cause;
    logic        link_not_running_cause;
    logic        clock_realign_cause;
    logic        oscillator_phase_cause;
    logic        divider_mismatch_cause;
    logic        hit_flags_clear;
    logic        hit_mask;
    logic        hit_irq_enable;
    logic        hit_pin_select;

    // Summary stays combinational so it tracks flag and mask edits at once
    assign unmasked_flags = alarm_flags_reg & ~alarm_enable_mask_reg; // [RL3] [RL14]
    assign alarm_summary = |unmasked_flags; // [RL1] [RL17]

    // Causes are levels from the core on this clock, so no synchroniser
    assign pll_unlock_cause = ~pll_locked; // [RL5]
    assign link_not_running_cause = link_enable_bit & ~data_transfer_state; // [RL6]
    assign clock_realign_cause = sysref_realign; // [RL7]
    assign oscillator_phase_cause = ~link_enable_bit // [RL8]
        | oscillator_sync // [RL9]
        | (phase_acc_a != phase_acc_b); // [RL10]
    assign divider_mismatch_cause = divider_a != divider_b; // [RL11]

    always_comb
    begin
        set_vec = 5'h00;
        set_vec[alarm_aggregator_pkg::POS_PLL_UNLOCK] = pll_unlock_cause;
        set_vec[alarm_aggregator_pkg::POS_LINK] = link_not_running_cause;
        set_vec[alarm_aggregator_pkg::POS_REALIGN] = clock_realign_cause;
        set_vec[alarm_aggregator_pkg::POS_OSC_PHASE] = oscillator_phase_cause;
        set_vec[alarm_aggregator_pkg::POS_DIV_MISMATCH] = divider_mismatch_cause;
    end

    assign addr_take = hsel & hready & (htrans == alarm_aggregator_pkg::HTRANS_NONSEQ);
    assign wr_active = bus_state_reg == alarm_aggregator_pkg::BUS_WRITE;

    // Clear register and flag register share one write path
    assign hit_flags_clear = wr_hit(wr_active, idx_reg, alarm_aggregator_pkg::IDX_ALARM_FLAGS)
        | wr_hit(wr_active, idx_reg, alarm_aggregator_pkg::IDX_IRQ_CLEAR);
    assign hit_mask = wr_hit(wr_active, idx_reg, alarm_aggregator_pkg::IDX_ALARM_ENABLE_MASK);
    assign hit_irq_enable = wr_hit(wr_active, idx_reg, alarm_aggregator_pkg::IDX_IRQ_ENABLE);
    assign hit_pin_select = wr_hit(wr_active, idx_reg, alarm_aggregator_pkg::IDX_PIN_SELECT);

    always_comb
    begin
        read_value = 32'h00000000;
        case (idx_reg)
            alarm_aggregator_pkg::IDX_ALARM_SUMMARY:
            begin
                read_value[alarm_aggregator_pkg::POS_SUMMARY] = alarm_summary; // [RL2]
            end
            alarm_aggregator_pkg::IDX_ALARM_FLAGS:
            begin
                read_value = pad_word(alarm_flags_reg); // [RL13]
            end
            alarm_aggregator_pkg::IDX_ALARM_ENABLE_MASK:
            begin
                read_value = pad_word(alarm_enable_mask_reg);
            end
            alarm_aggregator_pkg::IDX_IRQ_ENABLE:
            begin
                read_value = pad_word(irq_enable_reg);
            end
            alarm_aggregator_pkg::IDX_IRQ_STATUS:
            begin
                read_value = pad_word(alarm_flags_reg);
            end
            alarm_aggregator_pkg::IDX_PIN_SELECT:
            begin
                read_value[alarm_aggregator_pkg::POS_PIN_SELECT] = pin_select_reg;
            end
            default:
            begin
                read_value = 32'h00000000;
            end
        endcase
    end

    // Reads take one wait state so a write just before is always seen
    always_comb
    begin
        bus_state_next = bus_state_reg;
        idx_next = idx_reg;
        hrdata_next = hrdata_reg;
        case (bus_state_reg)
            alarm_aggregator_pkg::BUS_IDLE,
            alarm_aggregator_pkg::BUS_WRITE,
            alarm_aggregator_pkg::BUS_RD_DONE:
            begin
                if (addr_take)
                begin
                    idx_next = haddr[alarm_aggregator_pkg::IDX_MSB:alarm_aggregator_pkg::IDX_LSB];
                    bus_state_next = hwrite ? alarm_aggregator_pkg::BUS_WRITE : alarm_aggregator_pkg::BUS_RD_WAIT;
                end
                else
                begin
                    bus_state_next = alarm_aggregator_pkg::BUS_IDLE;
                end
            end
            alarm_aggregator_pkg::BUS_RD_WAIT:
            begin
                hrdata_next = read_value;
                bus_state_next = alarm_aggregator_pkg::BUS_RD_DONE;
            end
            default:
                bus_state_next = alarm_aggregator_pkg::BUS_IDLE;
        endcase
    end

    always_comb
    begin
        clr_vec = 5'h00;
        if (hit_flags_clear)
        begin
            clr_vec = hwdata[4:0]; // [RL12]
        end
        // Set beats clear, so a persisting cause cannot be hidden by software
        alarm_flags_next = apply_w1c(alarm_flags_reg, clr_vec, set_vec); // [RL12] [RL16]
    end

    always_comb
    begin
        alarm_enable_mask_next = alarm_enable_mask_reg;
        irq_enable_next = irq_enable_reg;
        pin_select_next = pin_select_reg;
        if (hit_mask)
        begin
            alarm_enable_mask_next = hwdata[4:0]; // [RL3]
        end
        if (hit_irq_enable)
        begin
            irq_enable_next = hwdata[4:0];
        end
        if (hit_pin_select)
        begin
            pin_select_next = hwdata[alarm_aggregator_pkg::POS_PIN_SELECT];
        end
    end

    // Pins leave from flip-flops so the pad never sees a decode glitch
    always_comb
    begin
        status_pin_next = pin_select_reg ? alarm_summary : calibration_status; // [RL4]
        irq_next = |(alarm_flags_next & irq_enable_next);
    end

    // Bus resets idle so a request in the first cycle after reset is taken
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            bus_state_reg <= alarm_aggregator_pkg::BUS_IDLE;
            idx_reg <= 10'h000;
            hrdata_reg <= 32'h00000000;
        end
        else
        begin
            bus_state_reg <= bus_state_next;
            idx_reg <= idx_next;
            hrdata_reg <= hrdata_next;
        end
    end

    // Flags reset set so software must acknowledge every alarm once
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            alarm_flags_reg <= alarm_aggregator_pkg::FLAGS_RESET; // [RL13]
        end
        else
        begin
            alarm_flags_reg <= alarm_flags_next;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            alarm_enable_mask_reg <= alarm_aggregator_pkg::MASK_RESET; // [RL15]
            irq_enable_reg <= alarm_aggregator_pkg::IRQ_ENABLE_RESET;
            pin_select_reg <= alarm_aggregator_pkg::PIN_SELECT_RESET;
        end
        else
        begin
            alarm_enable_mask_reg <= alarm_enable_mask_next;
            irq_enable_reg <= irq_enable_next;
            pin_select_reg <= pin_select_next;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            status_pin_reg <= 1'h0;
            irq_reg <= 1'h0;
        end
        else
        begin
            status_pin_reg <= status_pin_next;
            irq_reg <= irq_next;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = bus_state_reg != alarm_aggregator_pkg::BUS_RD_WAIT;
    assign hresp = alarm_aggregator_pkg::HRESP_OKAY;
    assign status_output_pin = status_pin_reg;
    assign irq = irq_reg;

endmodule
`default_nettype wire

// ===== verilog/alarm_aggregator_pkg.sv
// Package with register map, field layout and reset values of the alarm aggregator
`default_nettype none
package alarm_aggregator_pkg;

    localparam int unsigned FLAG_COUNT = 5;

    // Printed offsets are word indices; byte address is four times the index
    localparam logic [9:0] IDX_ALARM_SUMMARY     = 10'h2C0;
    localparam logic [9:0] IDX_ALARM_FLAGS       = 10'h2C1;
    localparam logic [9:0] IDX_ALARM_ENABLE_MASK = 10'h2C2;
    localparam logic [9:0] IDX_IRQ_CLEAR         = 10'h2C3;
    localparam logic [9:0] IDX_IRQ_ENABLE        = 10'h2C4;
    localparam logic [9:0] IDX_IRQ_STATUS        = 10'h2C5;
    localparam logic [9:0] IDX_PIN_SELECT        = 10'h2C6;

    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned IDX_MSB = 11;

    // Field positions in flags, mask, irq, summary and pin select registers
    localparam int unsigned POS_PLL_UNLOCK  = 4;
    localparam int unsigned POS_LINK        = 3;
    localparam int unsigned POS_REALIGN     = 2;
    localparam int unsigned POS_OSC_PHASE   = 1;
    localparam int unsigned POS_DIV_MISMATCH = 0;
    localparam int unsigned POS_SUMMARY     = 0;
    localparam int unsigned POS_PIN_SELECT  = 0;

    localparam logic [4:0] FLAGS_RESET      = 5'h1F;
    localparam logic [4:0] MASK_RESET       = 5'h1F;
    localparam logic [4:0] IRQ_ENABLE_RESET = 5'h00;
    localparam logic       PIN_SELECT_RESET = 1'h0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    typedef enum logic [3:0] {
        BUS_IDLE    = 4'h1,
        BUS_WRITE   = 4'h2,
        BUS_RD_WAIT = 4'h4,
        BUS_RD_DONE = 4'h8
    } bus_state_type;

endpackage
`default_nettype wire

// ===== bench/alarm_aggregator_chk.sv
// Checker for bus timing and alarm flag readback
`default_nettype none
module alarm_aggregator_chk #(parameter int unsigned DIV_WIDTH = 8) (
    input wire logic                 clk_sys,
    input wire logic                 sys_rst,
    input wire logic                 hsel,
    input wire logic [31:0]          haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic                 hready,
    input wire logic [31:0]          hrdata,
    input wire logic                 hreadyout,
    input wire logic                 pll_locked,
    input wire logic                 link_enable_bit,
    input wire logic                 data_transfer_state,
    input wire logic                 sysref_realign,
    input wire logic [DIV_WIDTH-1:0] divider_a,
    input wire logic [DIV_WIDTH-1:0] divider_b
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    wire logic tk = hsel && hready && htrans == alarm_aggregator_pkg::HTRANS_NONSEQ;
    wire logic rf = tk && !hwrite && haddr[11:2] == alarm_aggregator_pkg::IDX_ALARM_FLAGS;
    wire logic rs = tk && !hwrite && haddr[11:2] == alarm_aggregator_pkg::IDX_ALARM_SUMMARY;
    // Data is valid two edges after the address edge
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_rd_wait; tk && !hwrite |=> s_rd_wait; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_fast; tk && hwrite |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_sum_rsvd; rs |-> ##2 hrdata[31:1] == 31'h0; endproperty
    a_sum_rsvd: assert property (p_sum_rsvd) else $error("summary upper bits set");
    property p_flag_rsvd; rf |-> ##2 hrdata[31:5] == 27'h0; endproperty
    a_flag_rsvd: assert property (p_flag_rsvd) else $error("flags upper bits set");
    property p_pll; rf && !pll_locked |-> ##2 hrdata[4]; endproperty
    a_pll: assert property (p_pll) else $error("pll flag missing");
    property p_link; rf && link_enable_bit && !data_transfer_state |-> ##2 hrdata[3]; endproperty
    a_link: assert property (p_link) else $error("link flag missing");
    property p_realign; rf && sysref_realign |-> ##2 hrdata[2]; endproperty
    a_realign: assert property (p_realign) else $error("realign flag missing");
    property p_div; rf && divider_a != divider_b |-> ##2 hrdata[0]; endproperty
    a_div: assert property (p_div) else $error("divider flag missing");
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the alarm aggregator
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] A_SUM = alarm_aggregator_pkg::IDX_ALARM_SUMMARY;
    localparam logic [9:0] A_FLG = alarm_aggregator_pkg::IDX_ALARM_FLAGS;
    localparam logic [9:0] A_MSK = alarm_aggregator_pkg::IDX_ALARM_ENABLE_MASK;
    localparam logic [9:0] A_CLR = alarm_aggregator_pkg::IDX_IRQ_CLEAR;
    localparam logic [9:0] A_IEN = alarm_aggregator_pkg::IDX_IRQ_ENABLE;
    localparam logic [9:0] A_PIN = alarm_aggregator_pkg::IDX_PIN_SELECT;
    localparam logic [9:0] A_IST = alarm_aggregator_pkg::IDX_IRQ_STATUS;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic        pll_locked = 1'b1, link_enable_bit = 1'b1, data_transfer_state = 1'b1;
    logic        sysref_realign = 1'b0, oscillator_sync = 1'b0, calibration_status = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [63:0] phase_acc_b = 64'h0;
    logic [7:0]  divider_b = 8'h0;
    wire logic [31:0] hrdata;
    wire logic   hreadyout, hresp, status_output_pin, irq;
    int          n_mismatch = 0, samples_checked = 0, cyc = 0;
    int          bitpos[7] = '{4, 3, 2, 1, 1, 1, 0};
    alarm_aggregator uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pll_locked(pll_locked), .link_enable_bit(link_enable_bit),
        .data_transfer_state(data_transfer_state), .sysref_realign(sysref_realign),
        .oscillator_sync(oscillator_sync), .phase_acc_a(64'h0), .phase_acc_b(phase_acc_b), .divider_a(8'h0),
        .divider_b(divider_b), .calibration_status(calibration_status), .status_output_pin(status_output_pin),
        .irq(irq));
    initial forever #50 clk_sys = ~clk_sys;
    task automatic print_verdict();
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Ready is read in the second half so the edge value is never raced
    task automatic wait_rdy(output logic [31:0] d);
        logic r;
        forever
        begin
            @(negedge clk_sys);
            r = hreadyout;
            d = hrdata;
            @(posedge clk_sys);
            if (r)
                break;
        end
    endtask
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        hwrite <= wr;
        htrans <= alarm_aggregator_pkg::HTRANS_NONSEQ;
        haddr <= {20'h0, idx, 2'h0};
        wait_rdy(rd);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, idx, 32'h0, x);
        chk(x, exp);
    endtask
    task automatic cause(input int k, input logic on);
        case (k)
            0: pll_locked <= !on;
            1: data_transfer_state <= !on;
            2: sysref_realign <= on;
            3: link_enable_bit <= !on;
            4: oscillator_sync <= on;
            5: phase_acc_b <= {31'h0, on, 32'h0};
            default: divider_b <= {7'h0, on};
        endcase
    endtask
    // Pin output is one cycle behind, so two falling edges
    task automatic late_chk(input logic pin, input logic ir);
        repeat (2) @(negedge clk_sys);
        chk({29'h0, hresp, status_output_pin, irq}, {29'h0, alarm_aggregator_pkg::HRESP_OKAY, pin, ir});
        @(posedge clk_sys);
    endtask
    task automatic t_reset();
        rdc(A_FLG, 32'h1F);
        rdc(A_MSK, 32'h1F);
        rdc(A_SUM, 32'h0);
        wr(A_FLG, 32'h0);
        rdc(A_FLG, 32'h1F);
        wr(A_FLG, 32'hFF);
        rdc(A_FLG, 32'h0);
        rdc(A_IEN, 32'h0);
        rdc(A_PIN + 10'h1, 32'h0);
    endtask
    task automatic t_causes();
        logic [31:0] b;
        for (int k = 0; k < 7; k++)
        begin
            b = 32'h1 << bitpos[k];
            cause(k, 1'b1);
            wr(A_FLG, b);
            rdc(A_FLG, b);
            cause(k, 1'b0);
            rdc(A_FLG, b);
            wr(A_CLR, b);
            rdc(A_FLG, 32'h0);
        end
    endtask
    task automatic t_mask();
        cause(6, 1'b1);
        rdc(A_SUM, 32'h0);
        cause(6, 1'b0);
        wr(A_MSK, 32'h1E);
        rdc(A_SUM, 32'h1);
        wr(A_MSK, 32'h01);
        rdc(A_SUM, 32'h0);
        wr(A_MSK, 32'h1E);
    endtask
    task automatic t_out();
        wr(A_PIN, 32'h1);
        late_chk(1'b1, 1'b0);
        rdc(A_PIN, 32'h1);
        wr(A_IEN, 32'h1);
        late_chk(1'b1, 1'b1);
        rdc(A_IEN, 32'h1);
        rdc(A_IST, 32'h1);
        wr(A_CLR, 32'h1);
        late_chk(1'b0, 1'b0);
        rdc(A_IST, 32'h0);
        calibration_status <= 1'b1;
        wr(A_PIN, 32'h0);
        late_chk(1'b1, 1'b0);
    endtask
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_causes();
        t_mask();
        t_out();
        print_verdict();
    end
endmodule
bind alarm_aggregator alarm_aggregator_chk #(.DIV_WIDTH(DIV_WIDTH)) chk_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .pll_locked(pll_locked), .link_enable_bit(link_enable_bit),
    .data_transfer_state(data_transfer_state), .sysref_realign(sysref_realign), .divider_a(divider_a),
    .divider_b(divider_b));
`default_nettype wire
